// ---- src/dhw_pkg.sv ----
// ---------------------------------------------------------------
// Shared constants for the host word transfer block
// ---------------------------------------------------------------
package dhw_pkg;

  // Clock rate of sys_clk_in
  localparam int unsigned CLK_HZ = 25_000_000;

  // Request spacing in milliseconds
  localparam int unsigned REQ_GAP_12_MS = 23;
  localparam int unsigned REQ_GAP_8_MS = 18;

  // Derived spacing in clock cycles (exact at this rate)
  localparam int unsigned REQ_GAP_12_CYC = REQ_GAP_12_MS * (CLK_HZ / 1000);
  localparam int unsigned REQ_GAP_8_CYC = REQ_GAP_8_MS * (CLK_HZ / 1000);

  // Width of the request spacing timer
  localparam int unsigned GAP_TIMER_W = 20;

  // Host words per sector for each mode and density
  localparam logic [8:0] WORDS_12_SD = 9'h040;
  localparam logic [8:0] WORDS_12_DD = 9'h080;
  localparam logic [8:0] WORDS_8_SD = 9'h080;
  localparam logic [8:0] WORDS_8_DD = 9'h100;

  // First zero pad byte in 12-bit mode (words times 12 bits / 8)
  localparam logic [8:0] PAD_START_SD = 9'h060;
  localparam logic [8:0] PAD_START_DD = 9'h0C0;

  // Sector buffer size in bytes for each density
  localparam logic [8:0] SECTOR_BYTES_SD = 9'h080;
  localparam logic [8:0] SECTOR_BYTES_DD = 9'h100;

  // Reset values
  localparam logic [11:0] ACC_RESET = 12'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Transfer sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_WAIT,
    ST_PAD,
    ST_DONE
  } dhw_state_type;

endpackage

// ---- src/dhw_gap_timer.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Down counter that spaces transfer requests
// ---------------------------------------------------------------
module dhw_gap_timer #(
  parameter int unsigned WIDTH = 20
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] count_in,
  output logic expired_out
);

  // All timer state
  typedef struct packed {
    logic run;
    logic [WIDTH-1:0] cnt;
  } dhw_timer_type;

  dhw_timer_type state_reg;
  dhw_timer_type state_next;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (load_in) begin
      // Load wins over a running count
      state_next.run = 1'b1;
      state_next.cnt = count_in;
    end else if (state_reg.run && (state_reg.cnt != '0)) begin
      state_next.cnt = state_reg.cnt - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Stays high until the next load
  assign expired_out = state_reg.run && (state_reg.cnt == '0);

endmodule // dhw_gap_timer

// ---- src/dhw_word_xfer.sv ----
`timescale 1ns/1ps
// Functional notes
// (RULE1) Support 8-bit and 12-bit host word modes
// (RULE2) 12-bit single density: 64 words per sector
// (RULE3) 8-bit single density: 128 bytes per sector
// (RULE4) 12-bit double density: 128 words per sector
// (RULE5) 8-bit double density: 256 bytes per sector
// (RULE6) 12-bit mode zero-pads the buffer tail
// (RULE7) Next request 23 ms (12-bit) or 18 ms later
// (RULE8) Pending request held until host services it
// (RULE9) Host uses 8-bit mode for interchange media
// (RULE10) Drive select value 0 means left drive
// (RULE11) Exchange instruction acknowledges each pending request
// (RULE12) 8-bit read ORs into low byte; 12-bit replaces
// (RULE13) Word counter stops requests when sector full
module dhw_word_xfer
  import dhw_pkg::*;
#(
  parameter int unsigned GAP_12_CYC = REQ_GAP_12_CYC,
  parameter int unsigned GAP_8_CYC = REQ_GAP_8_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Sector transfer set-up, sampled on start_in
  input wire logic start_in,
  input wire logic fill_in,
  input wire logic mode_12bit_in,
  input wire logic double_density_in,
  input wire logic drive_select_in,
  // Host side
  input wire logic data_exchange_instruction_in,
  input wire logic [11:0] host_accumulator_in,
  output logic host_service_request_flag_out,
  output logic [11:0] host_accumulator_out,
  // Status
  output logic busy_out,
  output logic sector_done_out,
  output logic left_drive_out,
  // Controller side access to the sector buffer
  input wire logic ctl_wr_en_in,
  input wire logic [7:0] ctl_addr_in,
  input wire logic [7:0] ctl_wr_data_in,
  output logic [7:0] ctl_rd_data_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Whole module state; the buffer lives here as well
  typedef struct packed {
    dhw_state_type st;
    logic fill;
    logic mode12;
    logic dd;
    logic left;
    logic done;
    logic [8:0] count;
    logic [8:0] pad_ptr;
    logic [11:0] acc;
    logic [7:0] rd_data;
    logic [255:0][7:0] mem;
  } dhw_xfer_type;

  dhw_xfer_type state_reg;
  dhw_xfer_type state_next;

  // Timer control
  logic gap_load;
  logic gap_expired;
  logic [GAP_TIMER_W-1:0] gap_count;

  // Per-sector limits
  logic [8:0] words_limit;
  logic [8:0] pad_start;
  logic [8:0] sector_bytes;

  // Byte offsets of the 12-bit word pair
  logic [7:0] pair_base;
  logic [7:0] pair_mid;
  logic [7:0] pair_end;

  // Word picked from the buffer for the host
  logic [11:0] out_word;

  // ---------------------------------------------------------------
  // Limits from mode and density
  // ---------------------------------------------------------------
  always_comb begin
    if (state_reg.mode12) begin
      words_limit = state_reg.dd ? WORDS_12_DD : WORDS_12_SD; // [RULE2] [RULE4] [RULE13]
    end else begin
      words_limit = state_reg.dd ? WORDS_8_DD : WORDS_8_SD; // [RULE3] [RULE5] [RULE13]
    end
    pad_start = state_reg.dd ? PAD_START_DD : PAD_START_SD;
    sector_bytes = state_reg.dd ? SECTOR_BYTES_DD : SECTOR_BYTES_SD;
  end

  // Two 12-bit words pack into three bytes, high bits first
  assign pair_base = {1'b0, state_reg.count[7:1]} + {state_reg.count[7:1], 1'b0};
  assign pair_mid = pair_base + 8'h01;
  assign pair_end = pair_base + 8'h02;

  // ---------------------------------------------------------------
  // Word read out of the buffer for an empty transfer
  // ---------------------------------------------------------------
  always_comb begin
    if (!state_reg.mode12) begin
      out_word = {4'h0, state_reg.mem[state_reg.count[7:0]]};
    end else if (!state_reg.count[0]) begin
      out_word = {state_reg.mem[pair_base], state_reg.mem[pair_mid][7:4]};
    end else begin
      out_word = {state_reg.mem[pair_mid][3:0], state_reg.mem[pair_end]};
    end
  end

  // Request spacing depends on word mode
  always_comb begin
    if (state_reg.mode12) begin
      gap_count = GAP_TIMER_W'(GAP_12_CYC - 1); // [RULE7]
    end else begin
      gap_count = GAP_TIMER_W'(GAP_8_CYC - 1); // [RULE7]
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    gap_load = 1'b0;
    // Controller read port, registered
    state_next.rd_data = state_reg.mem[ctl_addr_in];
    case (state_reg.st)
      ST_IDLE: begin
        // Controller owns the buffer only while idle
        if (ctl_wr_en_in) begin
          state_next.mem[ctl_addr_in] = ctl_wr_data_in;
        end
        if (start_in) begin
          state_next.st = ST_REQ;
          state_next.fill = fill_in;
          state_next.mode12 = mode_12bit_in; // [RULE1]
          state_next.dd = double_density_in;
          state_next.left = ~drive_select_in; // [RULE10]
          state_next.count = 9'h000;
        end
      end
      ST_REQ: begin
        // Request stands with no time limit [RULE8]
        if (data_exchange_instruction_in) begin // [RULE11]
          if (state_reg.fill) begin
            if (!state_reg.mode12) begin
              // Only the low eight accumulator bits count in 8-bit mode
              state_next.mem[state_reg.count[7:0]] = host_accumulator_in[7:0];
            end else if (!state_reg.count[0]) begin
              state_next.mem[pair_base] = host_accumulator_in[11:4];
              state_next.mem[pair_mid][7:4] = host_accumulator_in[3:0];
            end else begin
              state_next.mem[pair_mid][3:0] = host_accumulator_in[11:8];
              state_next.mem[pair_end] = host_accumulator_in[7:0];
            end
          end else if (state_reg.mode12) begin
            state_next.acc = out_word; // [RULE12]
          end else begin
            state_next.acc = host_accumulator_in | out_word; // [RULE12]
          end
          state_next.count = state_reg.count + 9'h001;
          if ((state_reg.count + 9'h001) == words_limit) begin // [RULE13]
            // A full 12-bit fill still owes the zero tail
            if (state_reg.fill && state_reg.mode12) begin
              state_next.st = ST_PAD;
              state_next.pad_ptr = pad_start;
            end else begin
              state_next.st = ST_DONE;
            end
          end else begin
            state_next.st = ST_WAIT;
            gap_load = 1'b1; // [RULE7]
          end
        end
      end
      ST_WAIT: begin
        if (gap_expired) begin
          state_next.st = ST_REQ; // [RULE7]
        end
      end
      ST_PAD: begin
        // One zero byte per cycle up to the sector end
        state_next.mem[state_reg.pad_ptr[7:0]] = BYTE_RESET; // [RULE6]
        state_next.pad_ptr = state_reg.pad_ptr + 9'h001;
        if ((state_reg.pad_ptr + 9'h001) == sector_bytes) begin // [RULE6]
          state_next.st = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next.done = 1'b1;
        state_next.st = ST_IDLE;
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
      state_reg.st <= ST_IDLE;
      state_reg.acc <= ACC_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Request spacing timer
  // ---------------------------------------------------------------
  dhw_gap_timer #(
    .WIDTH(GAP_TIMER_W)
  ) u_gap_timer (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .load_in(gap_load),
    .count_in(gap_count),
    .expired_out(gap_expired)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Request is a plain decode so it drops with the acknowledge edge
  assign host_service_request_flag_out = (state_reg.st == ST_REQ); // [RULE8]
  assign host_accumulator_out = state_reg.acc;
  assign busy_out = (state_reg.st != ST_IDLE);
  assign sector_done_out = state_reg.done;
  assign left_drive_out = state_reg.left; // [RULE10]
  assign ctl_rd_data_out = state_reg.rd_data;

endmodule // dhw_word_xfer

// ---- verif/dhw_word_xfer_asserts.sv ----
`timescale 1ns/1ps
// ----------
// Port checks
// ----------
module dhw_word_xfer_asserts
  import dhw_pkg::*;
#(
  parameter int unsigned GAP_12_CYC = 20,
  parameter int unsigned GAP_8_CYC = 12
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic fill_in,
  input wire logic mode_12bit_in,
  input wire logic double_density_in,
  input wire logic drive_select_in,
  input wire logic data_exchange_instruction_in,
  input wire logic [11:0] host_accumulator_in,
  input wire logic host_service_request_flag_out,
  input wire logic [11:0] host_accumulator_out,
  input wire logic busy_out,
  input wire logic sector_done_out,
  input wire logic left_drive_out
);
  wire req = host_service_request_flag_out;
  wire xg = data_exchange_instruction_in;
  wire [11:0] acc_i = host_accumulator_in;
  wire [11:0] acc_o = host_accumulator_out;
  wire go = start_in && !busy_out; // Start counts only when idle
  logic m12_reg, f_reg, seen_reg; // Set-up of the sector in flight
  logic [8:0] n_reg, words_reg; // Words taken and words owed
  logic [19:0] gap_reg; // Cycles since the last exchange
  wire [19:0] gap_w = m12_reg ? 20'(GAP_12_CYC) : 20'(GAP_8_CYC);
  // Shadow of the sector set-up, so checks need no design internals
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {m12_reg, f_reg, seen_reg, n_reg, words_reg, gap_reg} <= '0;
    end else if (go) begin
      {m12_reg, f_reg, seen_reg, n_reg} <= {mode_12bit_in, fill_in, 10'h000};
      words_reg <= mode_12bit_in ? (double_density_in ? WORDS_12_DD : WORDS_12_SD)
        : (double_density_in ? WORDS_8_DD : WORDS_8_SD);
    end else if (req && xg) begin
      // Zero at the taking edge, so the count reads the gap on the rising edge
      {seen_reg, n_reg, gap_reg} <= {1'b1, n_reg + 9'h001, 20'h0_0000};
    end else begin
      gap_reg <= gap_reg + 20'h0_0001; // Cannot wrap within one run
    end
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence take_s;
    req && xg;
  endsequence
  req_hold_a: assert property (req && !xg |=> req)
    else $error("request dropped unserviced");
  req_drop_a: assert property (take_s |=> !req)
    else $error("request stays after exchange");
  req_gap_a: assert property ($rose(req) && seen_reg |-> gap_reg == gap_w)
    else $error("request spacing wrong");
  word_count_a: assert property (
    sector_done_out |-> n_reg == words_reg)
    else $error("word count wrong at sector end");
  sector_full_a: assert property (busy_out && n_reg == words_reg |-> !req)
    else $error("request after sector full");
  done_idle_a: assert property (sector_done_out |=> !busy_out && !sector_done_out)
    else $error("still busy after sector end");
  left_drive_a: assert property (go |=> left_drive_out == !$past(drive_select_in))
    else $error("drive 0 not marked left");
  byte_merge_a: assert property (take_s ##0 (!f_reg && !m12_reg) |=>
    (acc_o | $past(acc_i)) == acc_o && acc_o[11:8] == $past(acc_i[11:8]))
    else $error("byte not merged into accumulator");
  acc_keep_a: assert property (!(req && xg) |=> $stable(acc_o))
    else $error("accumulator changed without exchange");
endmodule // dhw_word_xfer_asserts

// ---- verif/dhw_host_model.sv ----
`timescale 1ns/1ps
// ----------
// Host model
// ----------
module dhw_host_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clr_in,
  input wire logic req_in,
  input wire logic [7:0] delay_in,
  input wire logic [11:0] base_in,
  output logic xchg_out,
  output logic [11:0] acc_out,
  output logic [8:0] count_out
);
  logic [7:0] wait_reg; // Cycles the pending request has waited
  // Each word differs, so a lost or doubled word shows
  assign acc_out = base_in + {3'h0, count_out};
  // Services a request after delay_in cycles, however long
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {xchg_out, wait_reg, count_out} <= '0;
    end else if (clr_in) begin
      count_out <= 9'h000;
    end else if (xchg_out) begin
      xchg_out <= 1'b0; // One exchange per request
      wait_reg <= 8'h00;
      count_out <= count_out + 9'h001;
    end else if (req_in && wait_reg >= delay_in) begin
      xchg_out <= 1'b1; // Late service is legal
    end else if (req_in) begin
      wait_reg <= wait_reg + 8'h01;
    end
  end
endmodule // dhw_host_model

// ---- verif/test_disk_host_word_transfer.sv ----
`timescale 1ns/1ps
// ----------
// Bench
// ----------
module test_disk_host_word_transfer
  import dhw_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, fill = 1'b0;
  logic m12 = 1'b0, dd = 1'b0, sel = 1'b0, req, xchg, busy, done, left;
  logic [7:0] dly = 8'h00, addr = 8'h00, rd;
  logic [11:0] base = 12'h000, acc_in, acc_out;
  logic [8:0] hcount; // Words the host exchanged this sector
  int n_errors = 0, cmp_count = 0;
  typedef struct packed {
    logic m12;
    logic dd;
    logic sel;
    logic [7:0] dly;
    logic [8:0] words;
  } dhw_row_type;
  // Fill rows; a slow host row, and 8-bit for interchange media
  dhw_row_type rows [4] = '{'{1'b1, 1'b0, 1'b0, 8'h00, WORDS_12_SD},
    '{1'b0, 1'b0, 1'b1, 8'h1E, WORDS_8_SD}, '{1'b1, 1'b1, 1'b1, 8'h03, WORDS_12_DD},
    '{1'b0, 1'b1, 1'b0, 8'h00, WORDS_8_DD}};
  // Short gaps keep the run brief
  dhw_word_xfer #(.GAP_12_CYC(20), .GAP_8_CYC(12)) dut (.sys_clk_in(clk), .rst_n_in(rst_n),
    .start_in(start), .fill_in(fill), .mode_12bit_in(m12), .double_density_in(dd),
    .drive_select_in(sel), .data_exchange_instruction_in(xchg), .host_accumulator_in(acc_in),
    .host_service_request_flag_out(req), .host_accumulator_out(acc_out), .busy_out(busy),
    .sector_done_out(done), .left_drive_out(left), .ctl_wr_en_in(1'b0), .ctl_addr_in(addr),
    .ctl_wr_data_in(8'h00), .ctl_rd_data_out(rd));
  dhw_host_model host (.clk_in(clk), .rst_n_in(rst_n), .clr_in(start), .req_in(req),
    .delay_in(dly), .base_in(base), .xchg_out(xchg), .acc_out(acc_in), .count_out(hcount));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d of %0d checks", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One whole sector; the end pulse is awaited under a bound
  task automatic sector(input logic f, md, d, s, input logic [7:0] w, input logic [11:0] b);
    int t;
    {fill, m12, dd, sel, dly, base, start} = {f, md, d, s, w, b, 1'b1};
    @(posedge clk);
    #1 start = 1'b0;
    for (t = 0; done !== 1'b1 && t < 20000; t++) begin
      @(posedge clk);
      #1;
    end
    check({11'h000, done}, 12'h001);
    check({11'h000, left}, {11'h000, ~s});
    @(posedge clk);
    #1;
  endtask
  task automatic read(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    @(posedge clk);
    #1;
    check({4'h0, rd}, {4'h0, exp});
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #2_000_000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    check({11'h000, busy}, 12'h000);
    check(acc_out, ACC_RESET);
    foreach (rows[i]) begin
      sector(1'b1, rows[i].m12, rows[i].dd, rows[i].sel, rows[i].dly, 12'hC00);
      check({3'h0, hcount}, {3'h0, rows[i].words});
    end
    // Empty the 8-bit double density sector: last byte merges
    sector(1'b0, 1'b0, 1'b1, 1'b0, 8'h02, 12'h300);
    check(acc_out, 12'h3FF);
    // 12-bit single density: packed words, then a zero tail
    sector(1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 12'hC00);
    read(8'h00, 8'hC0);
    read(8'h01, 8'h0C);
    read(8'h5F, 8'h3F);
    for (int a = 96; a < 128; a++) begin
      read(8'(a), 8'h00);
    end
    // Empty in 12-bit mode: the word replaces the accumulator
    sector(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 12'h300);
    check(acc_out, 12'hC3F);
    check({3'h0, hcount}, {3'h0, WORDS_12_SD});
    end_sim();
  end
endmodule // test_disk_host_word_transfer
bind dhw_word_xfer dhw_word_xfer_asserts #(.GAP_12_CYC(GAP_12_CYC), .GAP_8_CYC(GAP_8_CYC))
  chk (.*);
